// >>> rtl/pmc_top.sv
// Mic interface configuration: AXI4-Lite registers, clock, edge routing, packing, events
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_top
import pmc_pkg::*;
#(
   parameter int WORDS_PER_BUF = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite write channels
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Reference and microphone pins
   input wire logic ref_tick,
   input wire logic mic_data_in,
   output logic mic_clock_out,
   // Raw bits and left gain code to the decimator
   output logic left_bit_valid,
   output logic left_bit,
   output logic right_bit_valid,
   output logic right_bit,
   output logic [6:0] left_gain_out,
   // Decimated samples in, packed RAM words out
   input wire logic sample_valid,
   input wire logic [15:0] sample_left,
   input wire logic [15:0] sample_right,
   output logic [31:0] ram_word,
   output logic ram_word_valid,
   // Interrupt
   output logic irq
);
   logic [2:0] int_en_reg;
   logic [2:0] status_reg;
   logic enable_reg;
   logic [31:0] rate_reg;
   pmc_op_t op_reg;
   logic edge_reg;
   logic [6:0] gain_reg;
   pmc_state_t state_reg;
   logic [11:0] aw_addr_reg;
   logic aw_held_reg;
   logic [31:0] w_data_reg;
   logic w_held_reg;
   logic [15:0] half_reg;
   logic half_full_reg;
   logic [15:0] word_cnt_reg;
   logic [2:0] event_next;
   logic do_write;
   logic [11:0] wa;
   logic [31:0] wd;
   logic mclk;
   logic rise_p;
   logic fall_p;
   logic left_edge;
   logic right_edge;
   logic word_done;

   // Offset decode, shared by read and write paths
   function automatic logic pmc_mapped(input logic [11:0] a);
      return a == `PMC_OFS_EVENT_STATUS || a == `PMC_OFS_INT_ENABLE_SET ||
             a == `PMC_OFS_INT_DISABLE || a == `PMC_OFS_MODULE_ENABLE ||
             a == `PMC_OFS_CLK_DIVIDER || a == `PMC_OFS_CHANNEL_ROUTING ||
             a == `PMC_OFS_LEFT_GAIN;
   endfunction : pmc_mapped

   // Rate code to divisor; unknown codes fall back to the default ratio
   function automatic logic [5:0] pmc_divisor(input logic [31:0] code);
      if (code == `PMC_RATE_1000K)
         return `PMC_DIV_1000K;
      else if (code == `PMC_RATE_1067K)
         return `PMC_DIV_1067K;
      else
         return `PMC_DIV_DEFAULT;
   endfunction : pmc_divisor

   // Write address and data may arrive in either order; each is held once taken
   assign wa = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
   assign wd = w_held_reg ? w_data_reg : s_axi_wdata;
   assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                     (w_held_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

   // Write channel handshake; ready drops once a beat is held, until the response goes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            aw_addr_reg <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            w_data_reg <= s_axi_wdata;
         if (do_write)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= pmc_mapped(wa) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end
         else
         begin
            if (s_axi_awvalid && s_axi_awready)
               aw_held_reg <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
               w_held_reg <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) &&
                          !do_write && !s_axi_bvalid;
         s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) &&
                         !do_write && !s_axi_bvalid;
      end
   end

   // Configuration registers; byte lane 0 carries every narrow field
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         enable_reg <= 1'b0;
         rate_reg <= `PMC_RATE_DEFAULT;
         op_reg <= PMC_STEREO;
         edge_reg <= 1'b0;
         gain_reg <= `PMC_UNITY_GAIN_CODE;
      end
      else if (do_write)
      begin
         if (wa == `PMC_OFS_MODULE_ENABLE && s_axi_wstrb[0])
            enable_reg <= wd[0];
         if (wa == `PMC_OFS_CLK_DIVIDER)
         begin
            for (int b = 0; b < 4; b++)
               if (s_axi_wstrb[b])
                  rate_reg[b*8 +: 8] <= wd[b*8 +: 8];
         end
         if (wa == `PMC_OFS_CHANNEL_ROUTING && s_axi_wstrb[0])
         begin
            op_reg <= pmc_op_t'(wd[`PMC_ROUTE_OP_BIT]);
            edge_reg <= wd[`PMC_ROUTE_EDGE_BIT];
         end
         // Codes above the top step clamp rather than wrap
         if (wa == `PMC_OFS_LEFT_GAIN && s_axi_wstrb[0])
            gain_reg <= (wd[7:0] > 8'h50) ? `PMC_HIGHEST_GAIN_CODE : wd[6:0];
      end
   end

   // Interrupt enables: set register adds, disable register removes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         int_en_reg <= 3'h0;
      else if (do_write && s_axi_wstrb[0])
      begin
         if (wa == `PMC_OFS_INT_ENABLE_SET)
            int_en_reg <= int_en_reg | wd[2:0];
         else if (wa == `PMC_OFS_INT_DISABLE)
            int_en_reg <= int_en_reg & ~wd[2:0];
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PMC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= pmc_mapped(s_axi_araddr) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            unique case (s_axi_araddr)
               `PMC_OFS_EVENT_STATUS: s_axi_rdata <= {29'h0, status_reg};
               `PMC_OFS_INT_ENABLE_SET: s_axi_rdata <= {29'h0, int_en_reg};
               `PMC_OFS_INT_DISABLE: s_axi_rdata <= {29'h0, int_en_reg};
               `PMC_OFS_MODULE_ENABLE: s_axi_rdata <= {31'h0, enable_reg};
               `PMC_OFS_CLK_DIVIDER: s_axi_rdata <= rate_reg;
               `PMC_OFS_CHANNEL_ROUTING: s_axi_rdata <= {30'h0, edge_reg, op_reg};
               `PMC_OFS_LEFT_GAIN: s_axi_rdata <= {25'h0, gain_reg};
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Run state follows the enable bit, one cycle behind
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_reg <= PMC_IDLE;
      else
      begin
         unique case (state_reg)
            PMC_IDLE: if (enable_reg) state_reg <= PMC_RUN;
            PMC_RUN: if (!enable_reg) state_reg <= PMC_IDLE;
         endcase
      end
   end

   // Mic clock from the reference; divisor changes only land cleanly while capture_halted_event
   pmc_clk_gen #(.DIV_W(6)) u_clk_gen
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(state_reg == PMC_RUN),
      .ref_tick(ref_tick),
      .divisor(pmc_divisor(rate_reg)),
      .mic_clk(mclk),
      .rise_pulse(rise_p),
      .fall_pulse(fall_p)
   );

   // Edge routing: right takes the edge opposite to left, sharing one data line
   assign left_edge = edge_reg ? rise_p : fall_p;
   assign right_edge = edge_reg ? fall_p : rise_p;

   // Bit capture and registered pin and gain outputs
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mic_clock_out <= 1'b0;
         left_bit_valid <= 1'b0;
         left_bit <= 1'b0;
         right_bit_valid <= 1'b0;
         right_bit <= 1'b0;
         left_gain_out <= `PMC_UNITY_GAIN_CODE;
      end
      else
      begin
         mic_clock_out <= mclk;
         left_gain_out <= gain_reg;
         left_bit_valid <= left_edge;
         right_bit_valid <= right_edge && op_reg == PMC_STEREO;
         if (left_edge)
            left_bit <= mic_data_in;
         if (right_edge)
            right_bit <= mic_data_in;
      end
   end

   // Sample packing into RAM words
   always_ff @(posedge clk)
   begin
      if (sys_rst || state_reg == PMC_IDLE)
      begin
         ram_word <= 32'h00000000;
         ram_word_valid <= 1'b0;
         half_reg <= 16'h0000;
         half_full_reg <= 1'b0;
      end
      else
      begin
         ram_word_valid <= 1'b0;
         if (sample_valid && op_reg == PMC_STEREO)
         begin
            ram_word <= {sample_right, sample_left};
            ram_word_valid <= 1'b1;
         end
         else if (sample_valid && half_full_reg)
         begin
            ram_word <= {sample_left, half_reg};
            ram_word_valid <= 1'b1;
            half_full_reg <= 1'b0;
         end
         else if (sample_valid)
         begin
            half_reg <= sample_left;
            half_full_reg <= 1'b1;
         end
      end
   end

   // Buffer word count for the buffer-done event
   assign word_done = ram_word_valid && (word_cnt_reg == 16'(WORDS_PER_BUF - 1));
   always_ff @(posedge clk)
   begin
      if (sys_rst || state_reg == PMC_IDLE)
         word_cnt_reg <= 16'h0000;
      else if (ram_word_valid)
         word_cnt_reg <= word_done ? 16'h0000 : word_cnt_reg + 16'h0001;
   end

   // Event sources
   assign event_next[`PMC_EV_BEGUN] = state_reg == PMC_IDLE && enable_reg;
   assign event_next[`PMC_EV_HALTED] = state_reg == PMC_RUN && !enable_reg;
   assign event_next[`PMC_EV_BUF_DONE] = word_done;

   // Sticky status; an event in the clearing cycle wins over the clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         status_reg <= 3'h0;
      else if (do_write && wa == `PMC_OFS_EVENT_STATUS && s_axi_wstrb[0])
         status_reg <= (status_reg & ~wd[2:0]) | event_next;
      else
         status_reg <= status_reg | event_next;
   end

   // Level interrupt, gated by the enable bits
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq <= 1'b0;
      else
         irq <= |(status_reg & int_en_reg);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   int_disable_clr_a: assert property (
      do_write && wa == `PMC_OFS_INT_DISABLE && s_axi_wstrb[0]
      |=> int_en_reg == ($past(int_en_reg) & ~$past(wd[2:0])))
      else $error("disable write did not clear exactly the written enables");

   disable_readback_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `PMC_OFS_INT_DISABLE
      |=> s_axi_rvalid && s_axi_rdata == {29'h0, $past(int_en_reg)})
      else $error("disable register read did not return enable state");

   enable_follow_a: assert property (
      $rose(enable_reg) |=> state_reg == PMC_RUN)
      else $error("interface did not start after enable set");

   idle_no_clock_a: assert property (
      (state_reg == PMC_IDLE) [*3] |-> !mic_clock_out && !left_bit_valid && !right_bit_valid)
      else $error("mic clock or capture active while disabled");

   divisor_pick_a: assert property (
      state_reg == PMC_RUN && rate_reg == `PMC_RATE_1067K |-> u_clk_gen.count_reg < 6'h1e)
      else $error("wrong divisor for fastest rate");

   stereo_pack_a: assert property (
      state_reg == PMC_RUN && op_reg == PMC_STEREO && sample_valid ##1 state_reg == PMC_RUN
      |-> ram_word_valid && ram_word == {$past(sample_right), $past(sample_left)})
      else $error("stereo word not packed right high left low");

   mono_pack_a: assert property (
      state_reg == PMC_RUN && op_reg == PMC_MONO && sample_valid && half_full_reg
      ##1 state_reg == PMC_RUN |-> ram_word == {$past(sample_left), $past(half_reg)})
      else $error("mono word not packed earlier low later high");

   left_edge_sel_a: assert property (
      !edge_reg && fall_p |=> left_bit_valid && left_bit == $past(mic_data_in))
      else $error("left bit not captured on selected edge");

   gain_range_a: assert property (
      1'b1 |=> left_gain_out == $past(gain_reg) && gain_reg <= `PMC_HIGHEST_GAIN_CODE)
      else $error("gain output wrong or out of range");

   right_opposite_a: assert property (
      right_bit_valid |-> !left_bit_valid && $past(op_reg == PMC_STEREO))
      else $error("right channel shares the left edge or runs in mono");
endmodule : pmc_top

// >>> rtl/pmc_cfg.svh
// Register map, field positions, reset values and timing figures for the mic config block
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Register byte offsets
`define PMC_OFS_EVENT_STATUS 12'h104
`define PMC_OFS_INT_ENABLE_SET 12'h304
`define PMC_OFS_INT_DISABLE 12'h308
`define PMC_OFS_MODULE_ENABLE 12'h500
`define PMC_OFS_CLK_DIVIDER 12'h504
`define PMC_OFS_CHANNEL_ROUTING 12'h508
`define PMC_OFS_LEFT_GAIN 12'h518

// Event bit positions, shared by status and enable registers
`define PMC_EV_BEGUN 0
`define PMC_EV_HALTED 1
`define PMC_EV_BUF_DONE 2

// Routing fields
`define PMC_ROUTE_OP_BIT 0
`define PMC_ROUTE_EDGE_BIT 1

// Clock rate field codes and divisors of the 32 MHz reference
`define PMC_RATE_1000K 32'h08000000
`define PMC_RATE_DEFAULT 32'h08400000
`define PMC_RATE_1067K 32'h08800000
`define PMC_DIV_1000K 6'h20
`define PMC_DIV_DEFAULT 6'h1f
`define PMC_DIV_1067K 6'h1e
`define PMC_REF_MHZ 32

// Gain codes
`define PMC_LOWEST_GAIN_CODE 7'h00
`define PMC_UNITY_GAIN_CODE 7'h28
`define PMC_HIGHEST_GAIN_CODE 7'h50

// Bus answers
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

// >>> rtl/pmc_pkg.sv
// Types shared by the mic config block
package pmc_pkg;
   // Capture state, binary codes written out
   typedef enum logic [0:0]
   {
      PMC_IDLE = 1'b0,
      PMC_RUN = 1'b1
   } pmc_state_t;

   // Packing mode of the routing register
   typedef enum logic
   {
      PMC_STEREO = 1'b0,
      PMC_MONO = 1'b1
   } pmc_op_t;
endpackage : pmc_pkg

// >>> rtl/pmc_clk_gen.sv
// Microphone clock generator: divides reference ticks by a selectable ratio
`timescale 1ns/1ns
module pmc_clk_gen
#(
   parameter int DIV_W = 6
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   input wire logic ref_tick,
   input wire logic [DIV_W-1:0] divisor,
   // Generated clock and edge strobes
   output logic mic_clk,
   output logic rise_pulse,
   output logic fall_pulse
);
   logic [DIV_W-1:0] count_reg;
   logic [DIV_W-1:0] half_w;

   // High for the first half period; odd ratios get the shorter high half
   assign half_w = divisor >> 1;

   // Reference tick counter, held at zero while capture_halted_event
   always_ff @(posedge clk)
   begin
      if (sys_rst || !run)
         count_reg <= '0;
      else if (ref_tick)
         count_reg <= (count_reg == divisor - 1'b1) ? '0 : count_reg + 1'b1;
   end

   // Clock level and one-cycle edge strobes, all registered
   always_ff @(posedge clk)
   begin
      if (sys_rst || !run)
      begin
         mic_clk <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end
      else
      begin
         rise_pulse <= ref_tick && (count_reg == '0);
         fall_pulse <= ref_tick && (count_reg == half_w);
         if (ref_tick && count_reg == '0)
            mic_clk <= 1'b1;
         else if (ref_tick && count_reg == half_w)
            mic_clk <= 1'b0;
      end
   end
endmodule : pmc_clk_gen

// >>> dv/pmc_mic_model.sv
// Two microphones sharing one data line, one per clock phase
`timescale 1ns/1ns
module pmc_mic_model
(
   // Clock
   input wire logic clk,
   // Microphone clock in
   input wire logic mic_clk,
   // Shared data line and the bit each phase now drives
   output logic mic_data,
   output logic hi_bit,
   output logic lo_bit
);
   logic clk_q = 1'b0;
   int idle = 0;
   int dly = 0;
   logic b;
   initial
   begin
      mic_data = 1'b0;
      hi_bit = 1'b0;
      lo_bit = 1'b0;
   end
   // Drive late after each edge so data is steady at the sampling edge
   always @(posedge clk)
   begin
      b = 1'($urandom_range(1, 0));
      clk_q <= mic_clk;
      dly <= (mic_clk !== clk_q) ? 4 : (dly > 0) ? dly - 1 : 0;
      idle <= (mic_clk !== clk_q) ? 0 : (idle < 99) ? idle + 1 : idle;
      if (dly == 1 && mic_clk)
      begin
         hi_bit <= b;
         mic_data <= b;
      end
      else if (dly == 1)
      begin
         lo_bit <= b;
         mic_data <= b;
      end
      else if (idle > 80)
         mic_data <= ~mic_data; // Capture_halted_event clock: line released, no stale value
   end
endmodule : pmc_mic_model

// >>> dv/pmc_top_tb.sv
// Self-checking bench for the mic config block
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_top_tb;
   // Design connections
   logic clk, sys_rst, ref_tick, mic_din, mic_clk, lv, lb, rv, rb, smp_v, wd_v, irq;
   logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, hi_bit, lo_bit;
   logic [11:0] aw_a, ar_a;
   logic [31:0] w_d, r_d, wd;
   logic [1:0] b_resp, r_resp;
   logic [15:0] s_l, s_r, prev_l;
   logic [6:0] gain;
   int error_cnt = 0;
   int num_checks = 0;
   int exp_en = 0;
   int exp_st = 0;
   int tcnt = 0;
   localparam logic [1:0] OK = `PMC_RESP_OKAY;
   localparam logic [1:0] ERR = `PMC_RESP_SLVERR;
   localparam logic [11:0] A_DIS = `PMC_OFS_INT_DISABLE;
   localparam logic [11:0] A_SET = `PMC_OFS_INT_ENABLE_SET;
   localparam logic [11:0] A_STAT = `PMC_OFS_EVENT_STATUS;
   localparam logic [11:0] A_EN = `PMC_OFS_MODULE_ENABLE;
   localparam logic [11:0] A_DIV = `PMC_OFS_CLK_DIVIDER;
   localparam logic [11:0] A_ROUTE = `PMC_OFS_CHANNEL_ROUTING;
   localparam logic [11:0] A_GAIN = `PMC_OFS_LEFT_GAIN;

   // Small buffer size keeps the buffer-done event quick to reach
   pmc_top #(.WORDS_PER_BUF(2)) i_dut
   (
      .clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
      .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
      .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
      .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
      .ref_tick(ref_tick), .mic_data_in(mic_din), .mic_clock_out(mic_clk),
      .left_bit_valid(lv), .left_bit(lb), .right_bit_valid(rv), .right_bit(rb),
      .left_gain_out(gain), .sample_valid(smp_v), .sample_left(s_l), .sample_right(s_r),
      .ram_word(wd), .ram_word_valid(wd_v), .irq(irq)
   );

   pmc_mic_model i_mic (.clk(clk), .mic_clk(mic_clk), .mic_data(mic_din),
      .hi_bit(hi_bit), .lo_bit(lo_bit));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Reference tick every third clock
   always @(posedge clk)
   begin
      tcnt <= (tcnt == 2) ? 0 : tcnt + 1;
      ref_tick <= (tcnt == 2);
   end

   task automatic stop_test;
      if (error_cnt == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask : chk

   // Both write channels offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk);
         if (aw_v && aw_r) aw_v <= 1'b0;
         if (w_v && w_r) w_v <= 1'b0;
         if (b_v === 1'b1) break;
      end
      b_r <= 1'b0;
      if (n == 100)
      begin
         error_cnt++;
         stop_test();
      end
      chk("bresp", er, b_resp);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk);
         if (ar_v && ar_r) ar_v <= 1'b0;
         if (r_v === 1'b1) break;
      end
      r_r <= 1'b0;
      if (n == 100)
      begin
         error_cnt++;
         stop_test();
      end
      chk("rdata", e, r_d);
      chk("rresp", er, r_resp);
   endtask : rd

   initial
   begin
      int i, n, p, f, lc, rc, s, c, g, e, m;
      logic prev;
      static logic [31:0] codes [3] = '{`PMC_RATE_1000K, `PMC_RATE_DEFAULT, `PMC_RATE_1067K};
      static int divs [3] = '{32, 31, 30};
      sys_rst = 1'b1;
      smp_v = 1'b0;
      s_l = 16'h0;
      s_r = 16'h0;
      aw_v = 1'b0;
      w_v = 1'b0;
      b_r = 1'b0;
      ar_v = 1'b0;
      r_r = 1'b0;
      aw_a = 12'h0;
      ar_a = 12'h0;
      w_d = 32'h0;
      ref_tick = 1'b0;
      f = $urandom(32'h6f3f356e);
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values and an unmapped place
      rd(A_DIS, 32'h0, OK);
      rd(A_EN, 32'h0, OK);
      rd(A_DIV, `PMC_RATE_DEFAULT, OK);
      rd(A_ROUTE, 32'h0, OK);
      rd(A_GAIN, 32'h28, OK);
      chk("gain_out", 32'h28, gain);
      rd(12'h0f0, 32'h0, ERR);
      wr(12'h0f0, 32'h1, ERR);
      // Random set and clear of event enables
      for (i = 0; i < 6; i++)
      begin
         s = $urandom_range(7, 0);
         c = $urandom_range(7, 0);
         wr(A_SET, s, OK);
         wr(A_DIS, c, OK);
         exp_en = (exp_en | s) & ~c;
         rd(A_DIS, exp_en, OK);
      end
      // Gain codes at both ends, above range and random
      for (i = 0; i < 5; i++)
      begin
         g = (i == 0) ? 0 : (i == 1) ? 32'h50 : (i == 2) ? 32'h7f : 32'h28;
         if (i == 3) g = $urandom_range(79, 1);
         wr(A_GAIN, g, OK);
         e = (g > 32'h50) ? 32'h50 : g;
         rd(A_GAIN, e, OK);
         chk("gain_out", e, gain);
      end
      // Mic clock period per rate code; silence once disabled
      for (i = 0; i < 3; i++)
      begin
         wr(A_DIV, codes[i], OK);
         rd(A_DIV, codes[i], OK);
         wr(A_EN, 32'h1, OK);
         f = -1;
         p = 0;
         prev = mic_clk;
         for (n = 0; n < 300 && p == 0; n++)
         begin
            @(posedge clk);
            if (mic_clk && !prev && f >= 0) p = n - f;
            if (mic_clk && !prev && f < 0) f = n;
            prev = mic_clk;
         end
         chk("mic_period", divs[i] * 3, p);
         wr(A_EN, 32'h0, OK);
         exp_st |= 3;
         repeat (2) @(posedge clk);
         lc = 0;
         for (n = 0; n < 100; n++)
         begin
            @(posedge clk);
            lc += mic_clk + lv;
         end
         chk("idle_activity", 0, lc);
      end
      // Capture edge for every mode and edge setting; first capture may see a released line
      for (m = 0; m < 4; m++)
      begin
         wr(A_ROUTE, m, OK);
         wr(A_EN, 32'h1, OK);
         lc = 0;
         rc = 0;
         for (n = 0; n < 1000; n++)
         begin
            @(posedge clk);
            if (lv === 1'b1 && lc > 0) chk("left_bit", m[1] ? lo_bit : hi_bit, lb);
            if (rv === 1'b1 && rc > 0) chk("right_bit", m[1] ? hi_bit : lo_bit, rb);
            lc += (lv === 1'b1);
            rc += (rv === 1'b1);
         end
         chk("left_seen", 1, lc > 5);
         chk("right_seen", m[0] ? 0 : 1, m[0] ? rc : (rc > 5));
         wr(A_EN, 32'h0, OK);
      end
      // Packing of samples into words, stereo then mono
      for (m = 0; m < 2; m++)
      begin
         wr(A_ROUTE, m, OK);
         wr(A_EN, 32'h1, OK);
         c = 0;
         for (i = 0; i < 6; i++)
         begin
            @(posedge clk);
            s_l <= 16'($urandom);
            s_r <= 16'($urandom);
            smp_v <= 1'b1;
            @(posedge clk);
            smp_v <= 1'b0;
            for (n = 0; n < 4; n++)
            begin
               @(posedge clk);
               if (wd_v === 1'b1) chk("ram_word", m ? {s_l, prev_l} : {s_r, s_l}, wd);
               c += (wd_v === 1'b1);
            end
            prev_l = s_l;
         end
         chk("word_count", m ? 3 : 6, c);
         wr(A_EN, 32'h0, OK);
         exp_st |= 7;
      end
      // Events: raise, mask and clear the interrupt
      rd(A_STAT, exp_st, OK);
      wr(A_DIS, 32'h7, OK);
      wr(A_SET, 32'h4, OK);
      repeat (3) @(posedge clk);
      chk("irq_on", 1, irq);
      wr(A_DIS, 32'h4, OK);
      repeat (3) @(posedge clk);
      chk("irq_masked", 0, irq);
      rd(A_SET, 32'h0, OK);
      wr(A_SET, 32'h2, OK);
      repeat (3) @(posedge clk);
      chk("irq_on", 1, irq);
      wr(A_STAT, 32'h2, OK);
      repeat (3) @(posedge clk);
      chk("irq_cleared", 0, irq);
      rd(A_STAT, 32'h5, OK);
      rd(A_DIS, 32'h2, OK);
      stop_test();
   end
endmodule : pmc_top_tb
